// File: rtl/ipmd_ctrl.sv
// Purpose: posted/masked interrupt controller with dispatch sequencer
// Assumes: one 200 MHz clock, synchronous inputs, AHB-Lite word access
// Notes: zero-wait slave, response always OKAY
`include "ipmd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipmd_ctrl
	import ipmd_pkg::*;
(
	input  wire logic        i_clk_sys,	// system clock
	input  wire logic        i_nrst,	// sync reset, low
	input  wire logic        i_hsel,	// slave select
	input  wire logic [31:0] i_haddr,	// byte address
	input  wire logic [1:0]  i_htrans,	// transfer type
	input  wire logic        i_hwrite,	// write flag
	input  wire logic [2:0]  i_hsize,	// word only
	input  wire logic [31:0] i_hwdata,	// write data
	input  wire logic        i_hready,	// bus ready
	output logic [31:0]      o_hrdata,	// read data
	output logic             o_hreadyout,	// always ready
	output logic             o_hresp,	// always okay
	input  wire logic [23:0] i_src_evt,	// condition pulses
	input  wire logic [4:0]  i_gpio_lvl,	// port interrupt levels
	input  wire logic [1:0]  i_cap_in,	// capture inputs 0/1
	input  wire logic        i_instr_done,	// instruction boundary
	input  wire logic [15:0] i_pc,	// return address
	input  wire logic        i_flag_wr,	// core writes flags
	input  wire logic [7:0]  i_flag_wdata,	// flags value
	input  wire logic        i_return_from_irq_instr,	// return executed
	input  wire logic [15:0] i_return_from_irq_instr_pc,	// popped counter
	input  wire logic [7:0]  i_return_from_irq_instr_flags,	// popped flags
	output ipmd_push_s       o_push,	// stack push
	output ipmd_pcld_s       o_pcld,	// counter load
	output logic             o_take,	// dispatch starts
	output logic             o_busy,	// dispatch running
	output logic             o_irq_active,	// request active
	output logic [7:0]       o_flags,	// flag register
	output logic             o_irq	// capture interrupt
);
	// ****************************************
	// state
	// ****************************************
	logic [23:0] posted_q;	// posted flags
	logic [23:0] mask_q;	// source masks
	logic        swint_q;	// software post enable
	logic [3:0]  cap_sts_q;	// capture status
	logic [3:0]  cap_msk_q;	// capture mask
	logic [7:0]  flags_q;	// flag register
	logic [4:0]  gpio_q;	// previous port levels
	logic [1:0]  cap_q;	// previous capture levels
	ipmd_state_e st_q;	// dispatch state
	logic [3:0]  cnt_q;	// dispatch cycle
	logic [15:0] ret_pc_q;	// saved counter
	logic [7:0]  vec_q;	// winning vector
	logic [4:0]  win_idx_q;	// winning source
	logic        wr_q;	// write data phase
	logic [7:0]  wr_idx_q;	// write index
	logic        rd_q;	// read data phase

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [4:0] ipmd_first(input logic [23:0] v);
		logic [4:0] idx;
		idx = 5'd0;
		for (int i = 23; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [7:0] ipmd_byte(input logic [23:0] v, input logic [7:0] idx);
		logic [7:0] b;
		b = `IPMD_RST8;
		if (idx == `IPMD_IDX_CLR0 || idx == `IPMD_IDX_MSK0) begin
			b = v[7:0];
		end else if (idx == `IPMD_IDX_CLR1 || idx == `IPMD_IDX_MSK1) begin
			b = v[15:8];
		end else if (idx == `IPMD_IDX_CLR2 || idx == `IPMD_IDX_MSK2) begin
			b = v[23:16];
		end
		return b;
	endfunction

	// ****************************************
	// event detection
	// ****************************************
	logic [23:0] pending;	// posted and masked
	logic        active;	// request may be taken
	logic [4:0]  win;	// encoder result
	logic [23:0] hw_set;	// hardware posting
	logic [3:0]  cap_evt;	// capture edges
	logic [4:0]  gpio_rise;	// port edges
	logic        addr_ok;	// transfer accepted
	logic [7:0]  a_idx;	// address index
	logic [7:0]  wbyte;	// written byte
	logic [23:0] wr_clr;	// clear from write
	logic [23:0] wr_set;	// software post

	assign gpio_rise = i_gpio_lvl & ~gpio_q;
	assign cap_evt   = {~i_cap_in[1] & cap_q[1], i_cap_in[1] & ~cap_q[1],
		~i_cap_in[0] & cap_q[0], i_cap_in[0] & ~cap_q[0]};

	// hardware sets: pulses, port edges, capture events
	always_comb begin
		hw_set = i_src_evt & ~`IPMD_SRC_HWONLY;
		hw_set[`IPMD_GP0_SRC] = gpio_rise[0];
		hw_set[`IPMD_GP1_SRC] = gpio_rise[1];
		hw_set[`IPMD_GP2_SRC] = gpio_rise[2];
		hw_set[`IPMD_GP3_SRC] = gpio_rise[3];
		hw_set[`IPMD_GP4_SRC] = gpio_rise[4];
		hw_set[`IPMD_TCAP0_SRC] = |cap_evt[1:0];
		hw_set[`IPMD_TCAP1_SRC] = |cap_evt[3:2];
		hw_set = hw_set & `IPMD_SRC_IMPL;
	end

	assign pending = posted_q & mask_q;
	assign win     = ipmd_first(pending);
	// a return restores the enable in its own cycle, so pending work is taken there
	assign active  = (|pending) &&
		(i_return_from_irq_instr ? i_return_from_irq_instr_flags[`IPMD_GIE_BIT] : flags_q[`IPMD_GIE_BIT]);

	// ****************************************
	// bus slave
	// ****************************************
	assign addr_ok = i_hsel && i_htrans[1] && i_hready;
	assign a_idx   = i_haddr[9:2];
	assign wbyte   = i_hwdata[7:0];

	// address phase capture
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			wr_q     <= 1'b0;
			rd_q     <= 1'b0;
			wr_idx_q <= `IPMD_RST8;
		end else begin
			wr_q     <= addr_ok && i_hwrite && (i_haddr[31:10] == 22'h000000);
			rd_q     <= addr_ok && !i_hwrite;
			wr_idx_q <= a_idx;
		end
	end

	// read data registered at address phase
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_hrdata <= 32'h00000000;
		end else if (addr_ok && !i_hwrite) begin
			o_hrdata <= 32'h00000000;
			if (i_haddr[31:10] != 22'h000000) begin
				o_hrdata <= 32'h00000000;	// unmapped reads zero
			end else if (a_idx == `IPMD_IDX_CLR0 || a_idx == `IPMD_IDX_CLR1 ||
				a_idx == `IPMD_IDX_CLR2) begin
				o_hrdata[7:0] <= ipmd_byte(posted_q, a_idx);
			end else if (a_idx == `IPMD_IDX_MSK3) begin
				o_hrdata[`IPMD_SWINT_BIT] <= swint_q;
			end else if (a_idx == `IPMD_IDX_CAPSTS) begin
				o_hrdata[3:0] <= cap_sts_q;
			end else if (a_idx == `IPMD_IDX_CAPMSK) begin
				o_hrdata[3:0] <= cap_msk_q;
			end else if (a_idx == `IPMD_IDX_FLAGS) begin
				o_hrdata[7:0] <= flags_q;
			end else begin
				o_hrdata[7:0] <= ipmd_byte(mask_q, a_idx);
			end
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// write decode into clear and post vectors
	always_comb begin
		wr_clr = `IPMD_RST24;
		wr_set = `IPMD_RST24;
		if (wr_q && wr_idx_q == `IPMD_IDX_CLR0) begin
			wr_clr[7:0] = ~wbyte;
			wr_set[7:0] = swint_q ? wbyte : `IPMD_RST8;
		end else if (wr_q && wr_idx_q == `IPMD_IDX_CLR1) begin
			wr_clr[15:8] = ~wbyte;
			wr_set[15:8] = swint_q ? wbyte : `IPMD_RST8;
		end else if (wr_q && wr_idx_q == `IPMD_IDX_CLR2) begin
			wr_clr[23:16] = ~wbyte;
			wr_set[23:16] = swint_q ? wbyte : `IPMD_RST8;
		end
	end

	// ****************************************
	// posted flags and masks
	// ****************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			posted_q <= `IPMD_RST24;
			gpio_q   <= 5'h00;
			cap_q    <= 2'h0;
		end else begin
			gpio_q <= i_gpio_lvl;
			cap_q  <= i_cap_in;
			posted_q <= ((posted_q & ~wr_clr & ~((o_take ? 24'h000001 : `IPMD_RST24) << win))
				| hw_set | wr_set) & `IPMD_SRC_IMPL;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			mask_q  <= `IPMD_RST24;
			swint_q <= 1'b0;
		end else if (wr_q) begin
			case (wr_idx_q)
				`IPMD_IDX_MSK0: mask_q[7:0]   <= wbyte;
				`IPMD_IDX_MSK1: mask_q[15:8]  <= wbyte & 8'(`IPMD_SRC_IMPL >> 8);
				`IPMD_IDX_MSK2: mask_q[23:16] <= wbyte & 8'(`IPMD_SRC_IMPL >> 16);
				`IPMD_IDX_MSK3: swint_q <= wbyte[`IPMD_SWINT_BIT];
				default: ;
			endcase
		end
	end

	// ****************************************
	// capture status, mask and interrupt
	// ****************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			cap_sts_q <= 4'h0;
			cap_msk_q <= 4'h0;
		end else begin
			cap_sts_q <= (cap_sts_q & ~((wr_q && wr_idx_q == `IPMD_IDX_CAPSTS) ?
				wbyte[3:0] : 4'h0)) | cap_evt;
			if (wr_q && wr_idx_q == `IPMD_IDX_CAPMSK) begin
				cap_msk_q <= wbyte[3:0];
			end
		end
	end

	assign o_irq = |(cap_sts_q & cap_msk_q);

	// ****************************************
	// flag register
	// ****************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			flags_q <= `IPMD_RST8;
		end else if (st_q == IPMD_DISP && cnt_q == `IPMD_STEP_CLR) begin
			flags_q <= `IPMD_RST8;
		end else if (i_return_from_irq_instr) begin
			flags_q <= i_return_from_irq_instr_flags;
		end else if (i_flag_wr) begin
			flags_q <= i_flag_wdata;	// enable rise re-arms
		end
	end

	assign o_flags      = flags_q;
	assign o_irq_active = active;

	// ****************************************
	// dispatch sequencer
	// ****************************************
	assign o_take = (st_q == IPMD_IDLE) && i_instr_done && active;
	assign o_busy = (st_q == IPMD_DISP);

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			st_q      <= IPMD_IDLE;
			cnt_q     <= 4'h0;
			ret_pc_q  <= 16'h0000;
			vec_q     <= `IPMD_RST8;
			win_idx_q <= 5'h00;
		end else begin
			case (st_q)
				IPMD_IDLE: begin
					if (o_take) begin
						st_q      <= IPMD_DISP;
						cnt_q     <= 4'h0;
						ret_pc_q  <= i_return_from_irq_instr ? i_return_from_irq_instr_pc : i_pc;
						win_idx_q <= win;
						vec_q     <= {1'b0, win + 5'd1, 2'b00};
					end
				end
				IPMD_DISP: begin
					cnt_q <= cnt_q + 4'd1;
					if (cnt_q == `IPMD_DISP_CYC - 4'd1) begin
						st_q <= IPMD_IDLE;
					end
				end
				default: st_q <= IPMD_IDLE;
			endcase
		end
	end

	// pushes and counter load from flip-flops
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_push <= '0;
			o_pcld <= '0;
		end else begin
			o_push <= '0;
			o_pcld <= '0;
			if (o_take) begin
				o_push <= '{valid: 1'b1, data: i_return_from_irq_instr ? i_return_from_irq_instr_pc[15:8] : i_pc[15:8]};
			end else if (st_q == IPMD_DISP && cnt_q == `IPMD_STEP_PCH) begin
				o_push <= '{valid: 1'b1, data: ret_pc_q[7:0]};
			end else if (st_q == IPMD_DISP && cnt_q == `IPMD_STEP_PCL) begin
				o_push <= '{valid: 1'b1, data: flags_q};
			end else if (st_q == IPMD_DISP && cnt_q == `IPMD_STEP_LOAD) begin
				o_pcld <= '{load: 1'b1, value: {8'h00, vec_q}};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	disp_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take |=> o_busy [*8] ##1 o_busy [*5] ##1 !o_busy)
		else $error("dispatch length wrong");
	take_gie_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take |-> i_instr_done &&
		(flags_q[`IPMD_GIE_BIT] || i_return_from_irq_instr && i_return_from_irq_instr_flags[`IPMD_GIE_BIT]))
		else $error("take without enable");
	push_ord_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take |=> o_push.valid ##1 o_push.valid ##1 o_push.valid && o_push.data == $past(flags_q))
		else $error("push order wrong");
	flag_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take |-> ##5 flags_q == `IPMD_RST8)
		else $error("flags not cleared");
	vec_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take |-> ##6 o_pcld.load && o_pcld.value == {8'h00, 1'b0, $past(win, 6) + 5'd1, 2'b00})
		else $error("vector load wrong");
	mask_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		posted_q[0] && !mask_q[0] && !(wr_q && wr_idx_q == `IPMD_IDX_CLR0) |=> posted_q[0])
		else $error("masked flag lost");
	evt_post_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		hw_set[1] |=> posted_q[1])
		else $error("event not posted");
	cap_w1c_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		wr_q && wr_idx_q == `IPMD_IDX_CAPSTS && wbyte[0] && !cap_evt[0] |=> !cap_sts_q[0])
		else $error("capture flag not cleared");
	return_from_irq_instr_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_return_from_irq_instr && !o_busy |=> flags_q == $past(i_return_from_irq_instr_flags))
		else $error("flags not restored");
	prio_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_take && pending[0] |=> win_idx_q == 5'd0)
		else $error("priority wrong");
endmodule
`default_nettype wire

// File: rtl/ipmd_defs.svh
// Purpose: constants for the interrupt post/mask/dispatch block
// Assumes: included by the design file and the bench, not by ipmd_pkg.sv
// Notes: register offsets are word indices; byte address = index * 4
`ifndef IPMD_DEFS_SVH
`define IPMD_DEFS_SVH
// ****************************************
// register indices
// ****************************************
`define IPMD_IDX_CLR0      8'hda
`define IPMD_IDX_CLR1      8'hdb
`define IPMD_IDX_CLR2      8'hdc
`define IPMD_IDX_MSK0      8'he0
`define IPMD_IDX_MSK1      8'he1
`define IPMD_IDX_MSK2      8'he2
`define IPMD_IDX_MSK3      8'he3
`define IPMD_IDX_CAPSTS    8'h2c
`define IPMD_IDX_CAPMSK    8'h2d
`define IPMD_IDX_FLAGS     8'he4
// ****************************************
// fields and reset values
// ****************************************
`define IPMD_SRC_IMPL      24'h77e0ff
`define IPMD_SRC_HWONLY    24'h718090
`define IPMD_SWINT_BIT     7
`define IPMD_GIE_BIT       0
`define IPMD_CAP_W         4
`define IPMD_RST8          8'h00
`define IPMD_RST24         24'h000000
`define IPMD_TCAP0_SRC     15
`define IPMD_TCAP1_SRC     16
`define IPMD_GP0_SRC       4
`define IPMD_GP1_SRC       7
`define IPMD_GP2_SRC       20
`define IPMD_GP3_SRC       21
`define IPMD_GP4_SRC       22
// ****************************************
// dispatch timing
// ****************************************
`define IPMD_DISP_CYC      4'd13
`define IPMD_STEP_PCH      4'd0
`define IPMD_STEP_PCL      4'd1
`define IPMD_STEP_FLG      4'd2
`define IPMD_STEP_CLR      4'd3
`define IPMD_STEP_LOAD     4'd4
`endif

// File: rtl/ipmd_pkg.sv
// Purpose: types for the interrupt post/mask/dispatch block
// Assumes: nothing
// Notes: shared by design and bench
package ipmd_pkg;
	typedef enum logic {IPMD_IDLE, IPMD_DISP} ipmd_state_e;	// dispatch states
	typedef struct packed {
		logic       valid;	// one-cycle stack push
		logic [7:0] data;	// byte pushed
	} ipmd_push_s;
	typedef struct packed {
		logic        load;	// one-cycle counter load
		logic [15:0] value;	// new program counter
	} ipmd_pcld_s;
endpackage

// File: verification/interrupt_post_mask_dispatch_bench.sv
// Purpose: self-checking bench for the interrupt post/mask/dispatch block
// Assumes: zero-wait bus slave, core model on the dispatch link
// Notes: global enable is raised before the sources are unmasked, so earlier posting dispatches only once unmasked
`include "ipmd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_post_mask_dispatch_bench
	import ipmd_pkg::*;
;
	logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;	// clock and controls
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;	// bus address and data
	logic [1:0]  htrans = 2'b00, cap = 2'b00;	// transfer type, capture inputs
	logic [2:0]  hsize = 3'b010;	// word transfers
	logic [23:0] evt = 24'h0;	// condition pulses
	logic [4:0]  gpio = 5'h00;	// port levels
	logic        gie_req = 1'b0, rt_chk = 1'b0;	// enable request, return watch
	logic        hrdy, hresp, take, busy, act, irq, done, fwr, return_from_irq_instr;	// design and core status
	logic [15:0] cpc, rpc;	// core counters
	logic [7:0]  fwd, rfl, flags;	// flag bytes
	ipmd_push_s  push;	// stack push
	ipmd_pcld_s  pcld;	// counter load
	int          mismatches = 0, checks_done = 0, cycles = 0;	// bench counters
	logic [7:0]  ra [10] = '{`IPMD_IDX_CLR0, `IPMD_IDX_CLR1, `IPMD_IDX_CLR2, `IPMD_IDX_MSK0,
		`IPMD_IDX_MSK1, `IPMD_IDX_MSK2, `IPMD_IDX_MSK3, `IPMD_IDX_CAPSTS, `IPMD_IDX_CAPMSK,
		`IPMD_IDX_FLAGS};	// every register index
	logic [1:0]  cs [4] = '{2'b01, 2'b00, 2'b10, 2'b00};	// capture edge sequence
	ipmd_ctrl i_ipmd_ctrl (.i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.i_src_evt(evt), .i_gpio_lvl(gpio), .i_cap_in(cap), .i_instr_done(done), .i_pc(cpc),
		.i_flag_wr(fwr), .i_flag_wdata(fwd), .i_return_from_irq_instr(return_from_irq_instr), .i_return_from_irq_instr_pc(rpc),
		.i_return_from_irq_instr_flags(rfl), .o_push(push), .o_pcld(pcld), .o_take(take), .o_busy(busy),
		.o_irq_active(act), .o_flags(flags), .o_irq(irq));
	ipmd_core_model i_ipmd_core_model (.i_clk_sys(clk), .i_nrst(nrst), .i_take(take),
		.i_busy(busy), .i_push(push), .i_pcld(pcld), .i_gie_req(gie_req), .o_done(done),
		.o_pc(cpc), .o_flag_wr(fwr), .o_flag_wdata(fwd), .o_return_from_irq_instr(return_from_irq_instr), .o_return_from_irq_instr_pc(rpc),
		.o_return_from_irq_instr_flags(rfl));
	initial begin	// 200 MHz clock
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] ad(input logic [7:0] idx);	// index to byte address
		return {22'h0, idx, 2'b00};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin	// report at once
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one bus transfer, address held until ready, data until ready again
	task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= ad(idx);
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(idx, 1'b1, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
		bus(idx, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask
	// waits for a take, then watches the dispatch that follows
	task automatic disp(input logic [15:0] vec);
		int          i, np, nb;	// counts
		logic [7:0]  pb [3];	// pushed bytes
		logic [15:0] pc, ld;	// return address, loaded counter
		i  = 0;
		np = 0;
		nb = 0;
		ld = 16'h0;
		do begin
			@(negedge clk);
			i++;
		end while (take !== 1'b1 && i < 300);
		chk("take_boundary", 32'h1, {31'h0, done});
		pc = cpc;
		for (i = 0; i < 16; i++) begin
			@(negedge clk);
			if (push.valid === 1'b1 && np < 3) begin	// keep push order
				pb[np] = push.data;
				np++;
			end
			if (pcld.load === 1'b1) ld = pcld.value;
			if (busy === 1'b1) nb++;
			if (i == 6) chk("flags_cleared", 0, flags);
		end
		chk("push_high", pc[15:8], pb[0]);
		chk("push_low", pc[7:0], pb[1]);
		chk("push_flags", 8'h01, pb[2]);
		chk("vector", vec, ld);
		chk("dispatch_len", 13, nb);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// a return with work pending must bring a take in its own cycle
	always @(negedge clk) begin
		if (rt_chk && done === 1'b1 && return_from_irq_instr === 1'b1) begin
			chk("take_after_return", 32'h1, {31'h0, take});
			rt_chk = 1'b0;
		end
	end
	always @(posedge clk) begin	// hang guard
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		foreach (ra[k]) rdc("reset_value", ra[k], 32'h0);
		wr(8'hff, 32'hff);
		rdc("unmapped", 8'hff, 32'h0);
		chk("resp_okay", 0, hresp);
		@(posedge clk);
		evt <= 24'h000002;
		@(posedge clk);
		evt <= 24'h000000;
		rdc("posted", `IPMD_IDX_CLR0, 32'h02);
		wr(`IPMD_IDX_MSK0, 32'h02);
		wr(`IPMD_IDX_MSK0, 32'h00);
		@(posedge clk);
		evt <= 24'h000004;
		@(posedge clk);
		evt <= 24'h000000;
		rdc("mask_keeps", `IPMD_IDX_CLR0, 32'h06);
		wr(`IPMD_IDX_CLR0, 32'h0d);
		rdc("clear_zero", `IPMD_IDX_CLR0, 32'h04);
		wr(`IPMD_IDX_MSK3, 32'h80);
		wr(`IPMD_IDX_CLR0, 32'h05);
		rdc("soft_post", `IPMD_IDX_CLR0, 32'h05);
		wr(`IPMD_IDX_CLR0, 32'h00);
		gpio <= 5'h01;
		repeat (3) @(posedge clk);
		rdc("port_edge", `IPMD_IDX_CLR0, 32'h10);
		wr(`IPMD_IDX_CLR0, 32'h00);
		repeat (3) @(posedge clk);
		rdc("port_level", `IPMD_IDX_CLR0, 32'h00);
		foreach (cs[k]) begin	// both edges of both inputs
			cap <= cs[k];
			repeat (3) @(posedge clk);
		end
		rdc("cap_status", `IPMD_IDX_CAPSTS, 32'h0f);
		rdc("cap0_post", `IPMD_IDX_CLR1, 32'h80);
		rdc("cap1_post", `IPMD_IDX_CLR2, 32'h01);
		wr(`IPMD_IDX_CAPMSK, 32'h01);
		@(negedge clk);
		chk("irq_on", 1, irq);
		wr(`IPMD_IDX_CAPSTS, 32'hf0);
		rdc("zero_keeps", `IPMD_IDX_CAPSTS, 32'h0f);
		wr(`IPMD_IDX_CAPSTS, 32'h01);
		@(negedge clk);
		chk("irq_off", 0, irq);
		rdc("one_clears", `IPMD_IDX_CAPSTS, 32'h0e);
		wr(`IPMD_IDX_CAPSTS, 32'h0e);
		wr(`IPMD_IDX_CLR1, 32'h00);
		wr(`IPMD_IDX_CLR2, 32'h00);
		wr(`IPMD_IDX_CLR0, 32'h03);
		gie_req <= 1'b1;
		repeat (20) @(posedge clk);
		chk("gie_set", 1, flags);
		chk("masked_idle", 0, act);
		rt_chk = 1'b1;
		wr(`IPMD_IDX_MSK0, 32'h03);
		disp(16'h0004);
		disp(16'h0008);
		repeat (30) @(posedge clk);
		rdc("taken_clears", `IPMD_IDX_CLR0, 32'h00);
		rdc("flags_back", `IPMD_IDX_FLAGS, 32'h01);
		final_report();
	end
endmodule
`default_nettype wire

// File: verification/ipmd_core_model.sv
// Purpose: core-side model of the dispatch link, with a byte stack
// Assumes: three-cycle instructions, routine of three instructions then return
// Notes: enable flag written once on request, restored only by return
`timescale 1ns/1ps
`default_nettype none
module ipmd_core_model
	import ipmd_pkg::*;
(
	input  wire logic        i_clk_sys,	// clock
	input  wire logic        i_nrst,	// sync reset, low
	input  wire logic        i_take,	// dispatch accepted
	input  wire logic        i_busy,	// dispatch running
	input  wire ipmd_push_s  i_push,	// stack push
	input  wire ipmd_pcld_s  i_pcld,	// counter load
	input  wire logic        i_gie_req,	// write enable once
	output logic             o_done,	// instruction boundary
	output logic [15:0]      o_pc,	// return address
	output logic             o_flag_wr,	// flags write
	output logic [7:0]       o_flag_wdata,	// flags value
	output logic             o_return_from_irq_instr,	// return executed
	output logic [15:0]      o_return_from_irq_instr_pc,	// popped counter
	output logic [7:0]       o_return_from_irq_instr_flags	// popped flags
);
	logic [7:0]  stk_q [$];	// program stack
	logic [1:0]  cyc_q;	// cycle within instruction
	logic [2:0]  nin_q;	// routine instructions run
	logic [1:0]  dep_q;	// routine depth
	logic        en_q;	// enable already written
	logic [15:0] pc_q;	// running counter
	// stepping stops while dispatch runs, so no boundary hides in it
	always_ff @(posedge i_clk_sys) begin
		o_done    <= 1'b0;
		o_flag_wr <= 1'b0;
		o_return_from_irq_instr    <= 1'b0;
		if (!i_nrst) begin	// core idle
			cyc_q <= 2'd0;
			dep_q <= 2'd0;
			nin_q <= 3'd0;
			en_q  <= 1'b0;
			pc_q  <= 16'h0120;
			stk_q.delete();
		end else begin
			if (i_push.valid) stk_q.push_back(i_push.data);	// bytes kept in push order
			if (i_pcld.load) begin	// enter routine at vector
				pc_q  <= i_pcld.value;
				dep_q <= dep_q + 2'd1;
				nin_q <= 3'd0;
			end else if (!i_busy && !i_take) begin
				if (cyc_q != 2'd2) cyc_q <= cyc_q + 2'd1;
				else begin	// instruction ends
					cyc_q  <= 2'd0;
					o_done <= 1'b1;
					if (dep_q != 2'd0 && nin_q == 3'd3) begin	// routine ends in return
						o_return_from_irq_instr       <= 1'b1;
						o_return_from_irq_instr_flags <= stk_q[$];
						o_return_from_irq_instr_pc    <= {stk_q[$-2], stk_q[$-1]};
						o_pc         <= {stk_q[$-2], stk_q[$-1]};
						pc_q         <= {stk_q[$-2], stk_q[$-1]};
						dep_q        <= dep_q - 2'd1;
						void'(stk_q.pop_back());
						void'(stk_q.pop_back());
						void'(stk_q.pop_back());
					end else begin	// ordinary step
						pc_q  <= pc_q + 16'd1;
						o_pc  <= pc_q + 16'd1;
						nin_q <= nin_q + 3'd1;
						if (i_gie_req && !en_q) begin
							o_flag_wr    <= 1'b1;
							o_flag_wdata <= 8'h01;
							en_q         <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire
